/* hdl/serial_out_cfg_pkg.sv */
// Purpose: Shared constants and types for the serial output framing setup.
// Assumes: 7-bit register index, 8-bit register data on the serial port.
// Notes:   Widths in bits, drive in microamps, skew in 50 ps steps.
package serial_out_cfg_pkg;
	// ============================================================
	// Register map
	localparam logic [6:0] OFS_FRAME = 7'h19;
	localparam logic [6:0] OFS_DRIVE = 7'h1A;
	localparam logic [6:0] OFS_RES   = 7'h1B;
	localparam logic [6:0] OFS_SKEW  = 7'h1E;
	localparam int BIT_SRC     = 7;
	localparam int BIT_DIV     = 4;
	localparam int BIT_STRETCH = 0;
	localparam int BIT_HALF    = 6;
	localparam int BIT_MAPEN   = 7;
	localparam int BIT_TWENTY  = 6;
	localparam int RES_LSB     = 3;
	localparam int DSKEW_LSB   = 2;
	localparam int CSKEW_LSB   = 0;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ============================================================
	// Serial port framing
	localparam logic [4:0] SPI_HDR_LAST = 5'h07;
	localparam logic [4:0] SPI_DATA_1ST = 5'h08;
	localparam logic [4:0] SPI_LAST     = 5'h0F;
	localparam logic [4:0] SPI_DONE     = 5'h10;
	localparam logic [3:0] SPI_MSB      = 4'hF;
	// ============================================================
	// Resolution and drive
	localparam logic [2:0] RES_18 = 3'h0;
	localparam logic [2:0] RES_16 = 3'h1;
	localparam logic [2:0] RES_14 = 3'h2;
	localparam logic [4:0] W14 = 5'h0E;
	localparam logic [4:0] W16 = 5'h10;
	localparam logic [4:0] W18 = 5'h12;
	localparam logic [4:0] W20 = 5'h14;
	localparam logic [4:0] NATIVE_BITS = W16;
	localparam logic [11:0] DRIVE_NORMAL_UA = 12'hDAC;
	localparam logic [11:0] DRIVE_HALF_UA   = 12'h6D6;
	localparam int SKEW_STEP_PS = 50;
	localparam logic [1:0] SKEW_NONE  = 2'h0;
	localparam logic [1:0] SKEW_ADV1  = 2'h1;
	localparam logic [1:0] SKEW_DEL1  = 2'h2;
	localparam logic [2:0] TAP_ZERO   = 3'h0;
	localparam logic [2:0] TAP_MINUS1 = 3'h7;
	localparam logic [2:0] TAP_PLUS1  = 3'h1;
	localparam logic [2:0] TAP_PLUS2  = 3'h2;
	// ============================================================
	// Types
	typedef enum logic [1:0] {
		LANE_TWO  = 2'b00,
		LANE_ONE  = 2'b01,
		LANE_HALF = 2'b10
	} lane_t;
	typedef enum logic [1:0] {
		DEC_BYPASS  = 2'b00,
		DEC_REAL    = 2'b01,
		DEC_COMPLEX = 2'b10
	} decim_t;
	typedef struct packed {
		logic       src;
		logic       div;
		logic       stretch;
		logic       half;
		logic       mapen;
		logic       twenty;
		logic [2:0] res;
		logic [1:0] dskew;
		logic [1:0] cskew;
	} cfg_t;
endpackage

/* hdl/serial_out_cfg.sv */
// Purpose: Serial output framing setup registers and frame clock timing.
// Assumes: Registers written over the serial configuration port.
// Notes:   One output bit per clk cycle; skew leaves as tap counts, drive as microamps.
//
// Functional notes
// RULE_01 - Software clears source bit outside complex two/one-lane.
// RULE_02 - Source bit set: frame clock from downconverter.
// RULE_03 - Software sets divide only two-lane bypass/real.
// RULE_04 - Stretch widens frame over both channels.
// RULE_05 - Software sets stretch only half-lane complex.
// RULE_06 - Half-drive bit halves output driver current.
// RULE_07 - Mapper enable in bypass sets resolution.
// RULE_08 - Twenty-bit output needs no mapper enable.
// RULE_09 - Twenty-bit enable gives 20-bit words.
// RULE_10 - Resolution code: 18, 16, 14 bits.
// RULE_11 - Decimation modes: 18 bits unless field changes.
// RULE_12 - Data skew field shifts serial data.
// RULE_13 - Bit-clock skew field shifts bit clock.
// RULE_14 - All fields reset to zero.
`timescale 1ns/1ps
`default_nettype none
module serial_out_cfg (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      spi_sclk,
	input  wire logic                      spi_sen_n,
	input  wire logic                      sdio_i,
	output logic                           sdio_o,
	output logic                           sdio_oe,
	input  wire serial_out_cfg_pkg::lane_t  lane_mode,
	input  wire serial_out_cfg_pkg::decim_t decim_mode,
	input  wire logic                      ddc_frame_clock,
	output logic                           frame_clock,
	output logic [4:0]                     word_bits,
	output logic [11:0]                    drive_current_ua,
	output logic [2:0]                     data_skew_taps,
	output logic [2:0]                     bit_clock_skew_taps,
	output logic                           res_code_invalid
);
	import serial_out_cfg_pkg::*;

	function automatic logic [4:0] res_bits(input logic [2:0] code);
		res_bits = (code == RES_16) ? W16 : (code == RES_14) ? W14 : W18;
	endfunction

	function automatic logic [2:0] skew_taps(input logic [1:0] code);
		skew_taps = (code == SKEW_NONE) ? TAP_ZERO :
			(code == SKEW_ADV1) ? TAP_MINUS1 :
			(code == SKEW_DEL1) ? TAP_PLUS1 : TAP_PLUS2;
	endfunction

	function automatic logic [7:0] reg_read(input logic [6:0] a, input cfg_t c);
		logic [7:0] r;
		r = REG_RESET;
		if (a == OFS_FRAME) begin
			r[BIT_SRC]     = c.src;
			r[BIT_DIV]     = c.div;
			r[BIT_STRETCH] = c.stretch;
		end
		if (a == OFS_DRIVE) begin
			r[BIT_HALF] = c.half;
		end
		if (a == OFS_RES) begin
			r[BIT_MAPEN]        = c.mapen;
			r[BIT_TWENTY]       = c.twenty;
			r[RES_LSB+:3]       = c.res;
		end
		if (a == OFS_SKEW) begin
			r[DSKEW_LSB+:2] = c.dskew;
			r[CSKEW_LSB+:2] = c.cskew;
		end
		reg_read = r;
	endfunction

	// ============================================================
	// Serial port, clocked by the port's own clock
	logic [4:0]  cnt_q;
	logic [14:0] sh_q;
	logic [7:0]  hdr_q;
	cfg_t        cfg_q;
	logic        wr_tgl_q;
	logic        out_q;
	logic        oe_q;

	wire         hdr_done = (cnt_q == SPI_HDR_LAST);
	wire         wr_now   = (cnt_q == SPI_LAST) && !hdr_q[7];
	wire [7:0]   wr_data  = {sh_q[6:0], sdio_i};
	wire [7:0]   rd_data  = reg_read(hdr_q[6:0], cfg_q);
	wire         rd_phase = hdr_q[7] && (cnt_q >= SPI_DATA_1ST) && (cnt_q <= SPI_LAST);
	wire [3:0]   rd_idx   = SPI_MSB - cnt_q[3:0];

	// The select line clears the framing so an aborted access leaves no trace.
	always_ff @(posedge spi_sclk or negedge rst_n or posedge spi_sen_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			sh_q  <= '0;
			hdr_q <= '0;
		end else if (spi_sen_n) begin
			cnt_q <= '0;
			sh_q  <= '0;
			hdr_q <= '0;
		end else begin
			cnt_q <= (cnt_q == SPI_DONE) ? cnt_q : cnt_q + 5'h01;
			sh_q  <= {sh_q[13:0], sdio_i};
			if (hdr_done) begin
				hdr_q <= {sh_q[6:0], sdio_i};
			end
		end
	end

	// Unmapped writes are dropped; reserved bits are not stored.
	always_ff @(posedge spi_sclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q    <= '0; // [RULE_14]
			wr_tgl_q <= 1'b0;
		end else if (wr_now && !spi_sen_n) begin
			wr_tgl_q <= ~wr_tgl_q;
			if (hdr_q[6:0] == OFS_FRAME) begin
				cfg_q.src     <= wr_data[BIT_SRC];
				cfg_q.div     <= wr_data[BIT_DIV];
				cfg_q.stretch <= wr_data[BIT_STRETCH];
			end
			if (hdr_q[6:0] == OFS_DRIVE) begin
				cfg_q.half <= wr_data[BIT_HALF];
			end
			if (hdr_q[6:0] == OFS_RES) begin
				cfg_q.mapen  <= wr_data[BIT_MAPEN];
				cfg_q.twenty <= wr_data[BIT_TWENTY];
				cfg_q.res    <= wr_data[RES_LSB+:3];
			end
			if (hdr_q[6:0] == OFS_SKEW) begin
				cfg_q.dskew <= wr_data[DSKEW_LSB+:2];
				cfg_q.cskew <= wr_data[CSKEW_LSB+:2];
			end
		end
	end

	// Read data changes on the falling edge so the master samples it settled.
	always_ff @(negedge spi_sclk or negedge rst_n or posedge spi_sen_n) begin
		if (!rst_n) begin
			out_q <= 1'b0;
			oe_q  <= 1'b0;
		end else if (spi_sen_n) begin
			out_q <= 1'b0;
			oe_q  <= 1'b0;
		end else begin
			out_q <= rd_phase ? rd_data[rd_idx[2:0]] : 1'b0;
			oe_q  <= rd_phase;
		end
	end

	assign sdio_o  = out_q;
	assign sdio_oe = oe_q;

	// ============================================================
	// Crossing into the sampling clock domain
	// The settings word is stable for a whole port access after each toggle,
	// far longer than the three clk edges the toggle needs to cross.
	logic [2:0] tgl_sync_q;
	cfg_t       live_q;

	wire        load = tgl_sync_q[1] ^ tgl_sync_q[2];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tgl_sync_q <= '0;
			live_q     <= '0; // [RULE_14]
		end else begin
			tgl_sync_q <= {tgl_sync_q[1:0], wr_tgl_q};
			if (load) begin
				live_q <= cfg_q;
			end
		end
	end

	// ============================================================
	// Word width and frame timing
	wire       bypass   = (decim_mode == DEC_BYPASS);
	wire       use_map  = live_q.mapen || !bypass; // [RULE_07] [RULE_11]
	wire [4:0] wb_d     = live_q.twenty ? W20 : // [RULE_09] [RULE_08]
		use_map ? res_bits(live_q.res) : NATIVE_BITS; // [RULE_10]
	wire       bad_code = !live_q.twenty && use_map &&
		(live_q.res != RES_18) && (live_q.res != RES_16) && (live_q.res != RES_14);
	wire [5:0] lane_bits = (lane_mode == LANE_TWO) ? {2'b00, wb_d[4:1]} :
		(lane_mode == LANE_HALF) ? {wb_d, 1'b0} : {1'b0, wb_d};
	wire       dbl      = live_q.div || live_q.stretch; // [RULE_04]
	wire [6:0] period_w = dbl ? {lane_bits, 1'b0} : {1'b0, lane_bits};
	wire [6:0] last_cnt = period_w - 7'h01;

	logic [6:0]  fcnt_q;
	logic        frame_clock_q;
	logic [4:0]  word_bits_q;
	logic [11:0] drive_q;
	logic [2:0]  dtap_q;
	logic [2:0]  ctap_q;
	logic        bad_q;

	wire frame_clock_core = (fcnt_q < {1'b0, period_w[6:1]});
	wire frame_clock_d    = live_q.src ? ddc_frame_clock : frame_clock_core; // [RULE_02]

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fcnt_q        <= '0;
			frame_clock_q <= 1'b0;
			word_bits_q   <= NATIVE_BITS;
			drive_q       <= DRIVE_NORMAL_UA;
			dtap_q        <= TAP_ZERO;
			ctap_q        <= TAP_ZERO;
			bad_q         <= 1'b0;
		end else begin
			fcnt_q        <= (fcnt_q >= last_cnt) ? 7'h00 : fcnt_q + 7'h01;
			frame_clock_q <= frame_clock_d;
			word_bits_q   <= wb_d;
			drive_q       <= live_q.half ? DRIVE_HALF_UA : DRIVE_NORMAL_UA; // [RULE_06]
			dtap_q        <= skew_taps(live_q.dskew); // [RULE_12]
			ctap_q        <= skew_taps(live_q.cskew); // [RULE_13]
			bad_q         <= bad_code;
		end
	end

	assign frame_clock         = frame_clock_q;
	assign word_bits           = word_bits_q;
	assign drive_current_ua    = drive_q;
	assign data_skew_taps      = dtap_q;
	assign bit_clock_skew_taps = ctap_q;
	assign res_code_invalid    = bad_q;

	// ============================================================
	// Checks
	logic seen_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seen_q <= 1'b0;
		end else if (load) begin
			seen_q <= 1'b1;
		end
	end

	// A frame only counts once settings and modes have held still for longer
	// than the longest frame, so a change never shows up as a short run.
	lane_t      lane_seen_q;
	decim_t     dec_seen_q;
	logic [6:0] calm_q;
	logic [6:0] hi_run_q;

	wire        moved  = load || (lane_mode != lane_seen_q) ||
		(decim_mode != dec_seen_q);
	wire        steady = &calm_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lane_seen_q <= LANE_TWO;
			dec_seen_q  <= DEC_BYPASS;
			calm_q      <= '0;
			hi_run_q    <= '0;
		end else begin
			lane_seen_q <= lane_mode;
			dec_seen_q  <= decim_mode;
			calm_q      <= moved ? 7'h00 : (steady ? calm_q : calm_q + 7'h01);
			hi_run_q    <= frame_clock ? hi_run_q + 7'h01 : 7'h00;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_load_seen;
		tgl_sync_q[1] != tgl_sync_q[2];
	endsequence

	sequence s_full_high_run;
		steady && !live_q.src && $fell(frame_clock);
	endsequence

	a_reset_zero_cfg: assert property (!seen_q |-> live_q == '0) // [RULE_14]
		else $error("Settings left zero state before any write.");
	a_src_ddc_frame: assert property (live_q.src // [RULE_02]
		|=> frame_clock == $past(ddc_frame_clock))
		else $error("Frame clock not taken from downconverter.");
	a_stretch_period: assert property (live_q.stretch && lane_mode == LANE_HALF // [RULE_04]
		|-> period_w == {wb_d, 2'b00})
		else $error("Stretched frame does not span both channels.");
	a_stretch_high_run: assert property (s_full_high_run // [RULE_04]
		##0 (live_q.stretch && lane_mode == LANE_HALF) |-> hi_run_q == {1'b0, word_bits, 1'b0})
		else $error("Stretched frame clock high time wrong.");
	a_default_high_run: assert property (s_full_high_run // [RULE_14]
		##0 (lane_mode == LANE_ONE && !live_q.div && !live_q.stretch)
		|-> hi_run_q == {3'b000, word_bits[4:1]})
		else $error("Plain frame clock high time wrong.");
	a_drive_half_cur: assert property (live_q.half && $stable(live_q.half) // [RULE_06]
		|=> drive_current_ua == DRIVE_HALF_UA)
		else $error("Half drive current not applied.");
	a_drive_normal: assert property (!live_q.half && $stable(live_q.half) // [RULE_06]
		|=> drive_current_ua == DRIVE_NORMAL_UA)
		else $error("Normal drive current not applied.");
	a_mapper_bypass: assert property (bypass && live_q.mapen && !live_q.twenty // [RULE_07]
		&& live_q.res == RES_16 ##1 $stable(live_q) |-> word_bits == W16)
		else $error("Mapper width not applied in bypass.");
	a_twenty_width: assert property (s_load_seen ##1 live_q.twenty[*2] // [RULE_09]
		|-> word_bits == W20)
		else $error("Twenty-bit output not applied.");
	a_res_code_14: assert property (!live_q.twenty && use_map // [RULE_10]
		&& live_q.res == RES_14 |=> word_bits == W14 || $changed(live_q) || $changed(decim_mode))
		else $error("Fourteen-bit code not applied.");
	a_bad_res_flag: assert property (!live_q.twenty && use_map // [RULE_10]
		&& live_q.res > RES_14 |=> res_code_invalid)
		else $error("Unsupported resolution code not flagged.");
	a_decim_default: assert property (!bypass && !live_q.twenty // [RULE_11]
		&& live_q.res == RES_18 && !live_q.mapen |=> word_bits == W18 || $changed(live_q))
		else $error("Decimation default width not eighteen.");
	a_data_skew_adv: assert property (live_q.dskew == SKEW_ADV1 // [RULE_12]
		&& $stable(live_q.dskew) |=> data_skew_taps == TAP_MINUS1)
		else $error("Data advance not applied.");
	a_data_skew_del2: assert property (&live_q.dskew // [RULE_12]
		|=> data_skew_taps == TAP_PLUS2)
		else $error("Data double delay not applied.");
	a_clk_skew_del: assert property (live_q.cskew == SKEW_DEL1 // [RULE_13]
		&& $stable(live_q.cskew) |=> bit_clock_skew_taps == TAP_PLUS1)
		else $error("Bit clock delay not applied.");
	a_clk_skew_adv: assert property (live_q.cskew == SKEW_ADV1 // [RULE_13]
		|=> bit_clock_skew_taps == TAP_MINUS1)
		else $error("Bit clock advance not applied.");
endmodule
`default_nettype wire

/* bench/frame_rx_model.sv */
// Purpose: Capture receiver model that measures the frame clock.
// Assumes: Frame clock is sampled on the sampling clock.
// Notes:   Lengths are in clk cycles, last complete frame only.
`timescale 1ns/1ps
`default_nettype none
module frame_rx_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       frame_clock,
	output logic      [7:0] hi_len,
	output logic      [7:0] per_len
);
	logic [7:0] cnt_q;
	logic       prev_q;
	// ============================================================
	// Edge timing
	// A receiver locks on the rising edge, so periods count rise to rise.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
			prev_q <= 1'b0;
			hi_len <= 8'h00;
			per_len <= 8'h00;
		end else begin
			prev_q <= frame_clock;
			cnt_q <= cnt_q + 8'h01;
			if (frame_clock && !prev_q) begin
				per_len <= cnt_q + 8'h01;
				cnt_q <= 8'h00;
			end
			if (!frame_clock && prev_q) begin
				hi_len <= cnt_q + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

/* bench/serial_out_cfg_tb.sv */
// Purpose: Self-checking bench for the serial output setup block.
// Assumes: Serial port clock of 80 ns runs only within frames.
// Notes:   Settings are given twelve clk cycles to reach the outputs.
`timescale 1ns/1ps
`default_nettype none
module serial_out_cfg_tb;
	import serial_out_cfg_pkg::*;
	logic        clk = 0, rst_n = 0, sclk = 0, sen_n = 1, sdi = 0, ddc = 0;
	lane_t       lane = LANE_ONE;
	decim_t      dec = DEC_BYPASS;
	wire logic   sdo, oe, fc, inv;
	wire logic [4:0]  wb;
	wire logic [11:0] cur;
	wire logic [2:0]  dt, ct;
	wire logic [7:0]  hi, per;
	int          n_errors = 0;
	int          num_checks = 0;
	logic [7:0]  rd;
	logic [7:0]  ro;
	logic [2:0]  taps [4] = '{TAP_ZERO, TAP_MINUS1, TAP_PLUS1, TAP_PLUS2};
	logic [4:0]  wid [4] = '{W18, W16, W14, W18};
	always #2.5 clk = ~clk;
	serial_out_cfg dut (.clk(clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_sen_n(sen_n),
		.sdio_i(sdi), .sdio_o(sdo), .sdio_oe(oe), .lane_mode(lane), .decim_mode(dec),
		.ddc_frame_clock(ddc), .frame_clock(fc), .word_bits(wb), .drive_current_ua(cur),
		.data_skew_taps(dt), .bit_clock_skew_taps(ct), .res_code_invalid(inv));
	frame_rx_model rx (.clk(clk), .rst_n(rst_n), .frame_clock(fc), .hi_len(hi),
		.per_len(per));
	// ============================================================
	// Shared tasks
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	// Read data is taken in the low half before each rise, where it stands.
	task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] d);
		logic [15:0] f;
		f = {r, a, d};
		sen_n = 0;
		for (int i = 15; i >= 0; i--) begin
			sdi = f[i];
			#40;
			if (i < 8) rd[i] = sdo;
			if (i < 8) ro[i] = oe;
			sclk = 1;
			#40;
			sclk = 0;
		end
		#40;
		sen_n = 1;
		#80;
		repeat (12) @(negedge clk);
	endtask
	task automatic mode(input lane_t l, input decim_t m);
		@(negedge clk);
		lane = l;
		dec = m;
	endtask
	task automatic finish_test;
		if (n_errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ============================================================
	// Scenarios
	task automatic t_reset;
		logic [6:0] ofs [4] = '{OFS_FRAME, OFS_DRIVE, OFS_RES, OFS_SKEW};
		foreach (ofs[i]) begin
			xfer(1, ofs[i], 8'h00);
			chk(rd, REG_RESET);
			chk(ro, 8'hFF);
		end
		chk(oe, 1'b0);
		chk({dt, ct, wb}, {TAP_ZERO, TAP_ZERO, NATIVE_BITS});
		chk(cur, DRIVE_NORMAL_UA);
	endtask
	task automatic t_drive;
		xfer(0, OFS_DRIVE, 8'h40);
		chk(cur, DRIVE_HALF_UA);
		chk(ro, 8'h00);
		xfer(1, OFS_DRIVE, 8'h00);
		chk(rd, 8'h40);
		xfer(0, OFS_DRIVE, 8'h00);
		chk(cur, DRIVE_NORMAL_UA);
	endtask
	task automatic t_res;
		for (int c = 0; c < 4; c++) begin
			xfer(0, OFS_RES, 8'h80 | 8'(c << 3));
			chk(wb, wid[c]);
			chk(inv, c == 3);
		end
		xfer(0, OFS_RES, 8'h40);
		chk(wb, W20);
		mode(LANE_ONE, DEC_REAL);
		xfer(0, OFS_RES, 8'h00);
		chk(wb, W18);
		xfer(0, OFS_RES, 8'h08);
		chk(wb, W16);
		mode(LANE_ONE, DEC_BYPASS);
		xfer(0, OFS_RES, 8'h00);
		chk(wb, NATIVE_BITS);
	endtask
	task automatic t_skew;
		for (int c = 0; c < 4; c++) begin
			xfer(0, OFS_SKEW, 8'(c << 2) | 8'(3 - c));
			chk(dt, taps[c]);
			chk(ct, taps[3-c]);
		end
		xfer(0, 7'h1C, 8'hFF);
		xfer(1, 7'h1C, 8'h00);
		chk(rd, 8'h00);
	endtask
	task automatic t_frame;
		repeat (100) @(negedge clk);
		chk({hi, per}, {8'h08, 8'h10});
		mode(LANE_TWO, DEC_BYPASS);
		xfer(0, OFS_FRAME, 8'h10);
		repeat (100) @(negedge clk);
		chk({hi, per}, {8'h08, 8'h10});
		mode(LANE_HALF, DEC_COMPLEX);
		xfer(0, OFS_FRAME, 8'h01);
		repeat (200) @(negedge clk);
		chk({hi, per}, {8'h24, 8'h48});
		mode(LANE_TWO, DEC_COMPLEX);
		xfer(0, OFS_FRAME, 8'h80);
		ddc = 1;
		repeat (4) @(negedge clk);
		chk(fc, 1'b1);
		ddc = 0;
		repeat (4) @(negedge clk);
		chk(fc, 1'b0);
	endtask
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1;
		repeat (4) @(negedge clk);
		t_reset();
		t_drive();
		t_res();
		t_skew();
		t_frame();
		finish_test();
	end
endmodule
`default_nettype wire
